// file: shared/lcic_pkg.sv
// Package for the LCD cursor/ink overlay register bank.
// Assumes an Avalon-MM slave with 32-bit data, one register per word.
package lcic_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h70;
  localparam logic [7:0] IDX_START = 8'h71;
  localparam logic [7:0] IDX_XLO = 8'h72;
  localparam logic [7:0] IDX_XHI = 8'h73;
  localparam logic [7:0] IDX_YLO = 8'h74;
  localparam logic [7:0] IDX_YHI = 8'h75;
  localparam logic [7:0] IDX_BLUE0 = 8'h76;
  // Status register of this block (index chosen freely)
  localparam logic [7:0] IDX_STATUS = 8'h7F;
  // Field positions
  localparam int MODE_W = 2;
  localparam int SIGN_BIT = 7;
  localparam int BLUE_W = 5;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Start address encoding
  localparam int START_ZERO_SUB = 1024;
  localparam int START_UNIT = 8192;
  // Layer modes
  typedef enum logic [1:0] {
    LCIC_OFF = 2'b00,
    LCIC_CURSOR = 2'b01,
    LCIC_INK = 2'b10,
    LCIC_RSVD = 2'b11
  } lcic_mode_t;
endpackage

// file: testbench/lcic_regs_props.sv
// Checker for the cursor/ink overlay register bank.
// Assumes it is bound to lcic_regs and sees only its ports.
`timescale 1ns/1ps
module lcic_regs_props #(
  parameter int MEM_AW = 21
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Overlay
  input wire logic VNDP,
  input wire logic CURSOR_EN,
  input wire logic INK_EN,
  input wire logic [MEM_AW-1:0] BASE_ADDR,
  input wire logic BASE_VALID,
  input wire logic [10:0] POS_X,
  input wire logic [10:0] POS_Y,
  input wire logic [4:0] BLUE0
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [7:0] idx;
  logic rd_done;
  logic wr_blue;
  logic [4:0] blue_exp;
  assign idx = AVS_ADDRESS[9:2];
  assign rd_done = AVS_READ && !AVS_WAITREQUEST;
  assign wr_blue = AVS_WRITE && !AVS_WAITREQUEST && idx == 8'h76
    && AVS_BYTEENABLE[0];
  // Last blue value taken over the bus
  always_ff @(posedge CLK) begin
    if (RST) blue_exp <= 5'h00;
    else if (wr_blue) blue_exp <= AVS_WRITEDATA[4:0];
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_wait_first: assert property ($rose(AVS_READ || AVS_WRITE)
    |-> AVS_WAITREQUEST) else $error("no wait in first cycle");
  chk_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("wait longer than one cycle");
  chk_mode_excl: assert property (!(CURSOR_EN && INK_EN))
    else $error("cursor and ink both on");
  chk_pos_zero: assert property (!CURSOR_EN |-> POS_X == 11'h000
    && POS_Y == 11'h000) else $error("position out of cursor mode");
  chk_base_vndp: assert property ($changed(BASE_ADDR) && !$past(RST)
    && !$past(RST, 2) && !$past(RST, 3) |-> $past(VNDP) || $past(VNDP, 2))
    else $error("base moved outside vertical non-display");
  chk_blue_follow: assert property (wr_blue |-> ##2 BLUE0 == blue_exp)
    else $error("blue colour not applied");
  chk_unmapped_zero: assert property (rd_done && (idx < 8'h70
    || (idx > 8'h76 && idx != 8'h7F)) |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_mode_read: assert property (rd_done && idx == 8'h70
    |-> AVS_READDATA[31:2] == 30'h0
    && CURSOR_EN == (AVS_READDATA[1:0] == 2'b01)
    && INK_EN == (AVS_READDATA[1:0] == 2'b10))
    else $error("mode readback disagrees with outputs");
  // Main scenarios
  cover property (AVS_WRITE && !AVS_WAITREQUEST && idx == 8'h75);
  cover property ($changed(BASE_ADDR) && !$past(RST, 2));
  cover property (INK_EN);
endmodule // lcic_regs_props

bind lcic_regs lcic_regs_props #(.MEM_AW(MEM_AW)) u_props (.CLK(CLK),
  .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .VNDP(VNDP), .CURSOR_EN(CURSOR_EN),
  .INK_EN(INK_EN), .BASE_ADDR(BASE_ADDR), .BASE_VALID(BASE_VALID),
  .POS_X(POS_X), .POS_Y(POS_Y), .BLUE0(BLUE0));

// file: testbench/test_lcic_regs.sv
// Testbench for the cursor/ink overlay register bank.
// Assumes lcic_regs with default memory size and the bound checker.
`timescale 1ns/1ps
module test_lcic_regs;
  localparam logic [20:0] MSZ = 21'h140000;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, vndp = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wd = 32'h0, rdata, q, r;
  logic [3:0] be = 4'hF;
  logic wait_r, cur, ink, bval;
  logic [20:0] base;
  logic [10:0] px, py, ox = 11'h000, oy = 11'h000;
  logic [4:0] blue, ob = 5'h00;
  int n_mismatch = 0, tests_run = 0;
  logic [31:0] seed = 32'h766ED59A;
  always #10 clk = ~clk;
  lcic_regs #(.MEM_SIZE(MSZ), .START_MAX(160)) dut (.CLK(clk), .RST(rst),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
    .VNDP(vndp), .CURSOR_EN(cur), .INK_EN(ink), .BASE_ADDR(base),
    .BASE_VALID(bval), .POS_X(px), .POS_Y(py), .BLUE0(blue));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [20:0] base_of(input logic [7:0] n);
    return (n == 8'h00) ? MSZ - 21'h400 : MSZ - 21'(n) * 21'h2000;
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus access; holds the request until waitrequest is low
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    adr <= {i, 2'b00};
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk); while (wait_r !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic vpulse();
    vndp <= 1'b1;
    repeat (2) @(posedge clk);
    vndp <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [7:0] c;
    logic [7:0] pc;
    logic [7:0] cs [5];
    logic [9:0] x, y;
    logic sx, sy, pv;
    // Corner codes: first, last valid, first invalid, top, zero
    cs = '{8'h01, 8'hA0, 8'hA1, 8'hFF, 8'h00};
    pc = 8'h00;
    pv = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("base reset", {11'h0, MSZ - 21'h400}, {11'h0, base});
    bus(1'b1, 8'h60, 32'hFF);
    bus(1'b0, 8'h60, 32'h0);
    cmp("unmapped read", 32'h0, q);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h70, (rnd() & 32'hFFFFFFFC) | 32'(m));
      bus(1'b0, 8'h70, 32'h0);
      cmp("mode", 32'(m), q);
      cmp("cursor", 32'(m == 1), {31'h0, cur});
      cmp("ink", 32'(m == 2), {31'h0, ink});
    end
    bus(1'b1, 8'h70, 32'h1);
    for (int k = 0; k < 8; k++) begin
      c = (k < 5) ? cs[k] : 8'(rnd() % 32'hA1);
      bus(1'b1, 8'h71, {24'h0, c});
      if (pv) cmp("base held", {11'h0, base_of(pc)}, {11'h0, base});
      bus(1'b0, 8'h7F, 32'h0);
      cmp("status", {29'h0, !pv, 2'b01}, q);
      vpulse();
      pc = c;
      pv = (c <= 8'hA0);
      if (pv) cmp("base", {11'h0, base_of(c)}, {11'h0, base});
      cmp("valid", 32'(pv), {31'h0, bval});
    end
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      sx = r[0];
      sy = r[1];
      x = sx ? {4'h0, r[15:10]} : r[19:10];
      y = sy ? {4'h0, r[25:20]} : r[31:22];
      bus(1'b1, 8'h72, {24'h0, x[7:0]});
      bus(1'b1, 8'h73, {24'h0, sx, 5'h00, x[9:8]});
      bus(1'b1, 8'h74, {24'h0, y[7:0]});
      vpulse();
      cmp("x held", {21'h0, ox}, {21'h0, px});
      bus(1'b1, 8'h75, {24'h0, sy, 5'h00, y[9:8]});
      cmp("y held", {21'h0, oy}, {21'h0, py});
      vpulse();
      ox = {sx, x};
      oy = {sy, y};
      cmp("x", {21'h0, ox}, {21'h0, px});
      cmp("y", {21'h0, oy}, {21'h0, py});
    end
    bus(1'b1, 8'h70, 32'h3);
    cmp("x reserved", 32'h0, {21'h0, px});
    bus(1'b1, 8'h70, 32'h1);
    cmp("y back", {21'h0, oy}, {21'h0, py});
    // Ink layer moved one block below the top of memory
    bus(1'b1, 8'h71, 32'h01);
    bus(1'b1, 8'h70, 32'h2);
    for (int i = 8'h72; i <= 8'h75; i++) bus(1'b1, 8'(i), 32'h0);
    vpulse();
    cmp("x ink", 32'h0, {21'h0, px});
    cmp("ink on", 32'h1, {31'h0, ink});
    cmp("base ink", {11'h0, base_of(8'h01)}, {11'h0, base});
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      be <= r[11:8];
      bus(1'b1, 8'h76, r);
      if (r[8]) ob = r[4:0];
      cmp("blue", {27'h0, ob}, {27'h0, blue});
    end
    be <= 4'hF;
    bus(1'b0, 8'h76, 32'h0);
    cmp("blue read", {27'h0, ob}, {27'h0, q[4:0]});
    summarize();
  end
endmodule // test_lcic_regs

// file: verilog/lcic_regs.sv
// Register bank of the LCD cursor/ink overlay with staged updates.
// Assumes an Avalon-MM master and a vertical non-display level from
// the LCD timing generator, both synchronous to CLK.
//
// How it works
// R1 - Mode field: 00 off, 01 cursor, 10 ink, 11 reserved.
// R2 - Software keeps X and Y positions zero while ink mode runs.
// R3 - Start code 0 gives size-1024, code n gives size-n*8192.
// R4 - New start code applies from next vertical non-display period.
// R5 - X sign bit set means negative; software keeps magnitude <= 63.
// R6 - Y sign bit set means negative; software keeps magnitude <= 63.
// R7 - Ten-bit X is cursor column, valid only in cursor mode.
// R8 - Ten-bit Y is cursor row, valid only in cursor mode.
// R9 - X low, X high, Y low wait for a Y high write.
// R10 - Y high write commits at the next vertical non-display period.
// R11 - Five-bit blue colour 0 held in low bits and driven out.
// R12 - Software advised that start code zero suits cursor mode.
// R13 - Software keeps overlay clear of the dual-panel buffer.
// R14 - Reserved mode behaves as inactive, showing no pixels.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module lcic_regs #(
  parameter int MEM_AW = 21,
  parameter logic [20:0] MEM_SIZE = 21'h140000,
  parameter int START_MAX = 160
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Avalon-MM slave
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // LCD timing
  input wire logic VNDP,
  // Overlay outputs
  output logic CURSOR_EN,
  output logic INK_EN,
  output logic [MEM_AW-1:0] BASE_ADDR,
  output logic BASE_VALID,
  output logic [10:0] POS_X,
  output logic [10:0] POS_Y,
  output logic [4:0] BLUE0
);
  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  logic ack_reg;
  logic [7:0] idx;
  logic wr_go;
  logic rd_go;
  logic [7:0] wbyte;

  assign idx = AVS_ADDRESS[9:2];
  assign wbyte = AVS_WRITEDATA[7:0];
  // One wait state per access
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign wr_go = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
  assign rd_go = AVS_READ & ack_reg;

  // Acknowledge toggles after one cycle of waiting
  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
    end
  end

  // ----------------------------------------------------------
  // Software-visible registers
  // ----------------------------------------------------------
  logic [1:0] mode_reg;
  logic [7:0] start_reg;
  logic [7:0] xlo_reg;
  logic [7:0] xhi_reg;
  logic [7:0] ylo_reg;
  logic [7:0] yhi_reg;
  logic [4:0] blue_reg;
  logic start_pend_reg;
  logic pos_pend_reg;
  logic vndp_reg;
  logic vndp_rise;

  // Mode register
  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_reg <= lcic_pkg::RST_BYTE[1:0];
    end else if (wr_go && idx == lcic_pkg::IDX_MODE) begin
      mode_reg <= wbyte[lcic_pkg::MODE_W-1:0]; // [R1]
    end
  end

  // Start code register
  always_ff @(posedge CLK) begin
    if (RST) begin
      start_reg <= lcic_pkg::RST_BYTE;
    end else if (wr_go && idx == lcic_pkg::IDX_START) begin
      start_reg <= wbyte;
    end
  end

  // Position registers, sign bit and bits 1-0 kept in high bytes
  always_ff @(posedge CLK) begin
    if (RST) begin
      xlo_reg <= lcic_pkg::RST_BYTE;
      xhi_reg <= lcic_pkg::RST_BYTE;
      ylo_reg <= lcic_pkg::RST_BYTE;
      yhi_reg <= lcic_pkg::RST_BYTE;
    end else if (wr_go) begin
      if (idx == lcic_pkg::IDX_XLO) begin
        xlo_reg <= wbyte;
      end else if (idx == lcic_pkg::IDX_XHI) begin
        xhi_reg <= {wbyte[7], 5'h00, wbyte[1:0]};
      end else if (idx == lcic_pkg::IDX_YLO) begin
        ylo_reg <= wbyte;
      end else if (idx == lcic_pkg::IDX_YHI) begin
        yhi_reg <= {wbyte[7], 5'h00, wbyte[1:0]};
      end
    end
  end

  // Blue colour 0
  always_ff @(posedge CLK) begin
    if (RST) begin
      blue_reg <= lcic_pkg::RST_BYTE[4:0];
    end else if (wr_go && idx == lcic_pkg::IDX_BLUE0) begin
      blue_reg <= wbyte[lcic_pkg::BLUE_W-1:0]; // [R11]
    end
  end

  // ----------------------------------------------------------
  // Staging toward vertical non-display
  // ----------------------------------------------------------
  assign vndp_rise = VNDP & ~vndp_reg;

  // Edge detect of non-display period start
  always_ff @(posedge CLK) begin
    if (RST) begin
      vndp_reg <= 1'b0;
    end else begin
      vndp_reg <= VNDP;
    end
  end

  // Pending start update; a new write wins over the clear at commit
  always_ff @(posedge CLK) begin
    if (RST) begin
      start_pend_reg <= 1'b0;
    end else if (wr_go && idx == lcic_pkg::IDX_START) begin
      start_pend_reg <= 1'b1;
    end else if (vndp_rise) begin
      start_pend_reg <= 1'b0; // [R4]
    end
  end

  // Pending position update armed only by Y high write
  always_ff @(posedge CLK) begin
    if (RST) begin
      pos_pend_reg <= 1'b0;
    end else if (wr_go && idx == lcic_pkg::IDX_YHI) begin
      pos_pend_reg <= 1'b1; // [R9]
    end else if (vndp_rise) begin
      pos_pend_reg <= 1'b0; // [R10]
    end
  end

  logic start_apply;
  logic pos_apply;
  logic [7:0] start_act;
  logic [7:0] xlo_act;
  logic [7:0] xhi_act;
  logic [7:0] ylo_act;
  logic [7:0] yhi_act;

  assign start_apply = vndp_rise & start_pend_reg; // [R4]
  assign pos_apply = vndp_rise & pos_pend_reg; // [R9] [R10]

  // Active start code
  lcic_stage #(.W(8)) u_start (
    .clk(CLK),
    .rst(RST),
    .apply(start_apply),
    .d(start_reg),
    .q(start_act)
  );

  // Active X low
  lcic_stage #(.W(8)) u_xlo (
    .clk(CLK),
    .rst(RST),
    .apply(pos_apply),
    .d(xlo_reg),
    .q(xlo_act)
  );

  // Active X high
  lcic_stage #(.W(8)) u_xhi (
    .clk(CLK),
    .rst(RST),
    .apply(pos_apply),
    .d(xhi_reg),
    .q(xhi_act)
  );

  // Active Y low
  lcic_stage #(.W(8)) u_ylo (
    .clk(CLK),
    .rst(RST),
    .apply(pos_apply),
    .d(ylo_reg),
    .q(ylo_act)
  );

  // Active Y high
  lcic_stage #(.W(8)) u_yhi (
    .clk(CLK),
    .rst(RST),
    .apply(pos_apply),
    .d(yhi_reg),
    .q(yhi_act)
  );

  // ----------------------------------------------------------
  // Overlay outputs
  // ----------------------------------------------------------
  lcic_pkg::lcic_mode_t mode_dec;
  logic [MEM_AW-1:0] base_next;
  logic base_ok;

  // Mode decode; reserved counts as inactive
  always_comb begin
    case (mode_reg)
      2'b01: mode_dec = lcic_pkg::LCIC_CURSOR; // [R1]
      2'b10: mode_dec = lcic_pkg::LCIC_INK; // [R1]
      2'b11: mode_dec = lcic_pkg::LCIC_RSVD; // [R14]
      default: mode_dec = lcic_pkg::LCIC_OFF; // [R1]
    endcase
  end

  // Base address from the active code
  always_comb begin
    base_ok = 1'b1;
    if (start_act == 8'h00) begin
      base_next = MEM_SIZE[MEM_AW-1:0]
        - MEM_AW'(lcic_pkg::START_ZERO_SUB); // [R3]
    end else begin
      base_next = MEM_SIZE[MEM_AW-1:0]
        - MEM_AW'(int'(start_act) * lcic_pkg::START_UNIT); // [R3]
      if (int'(start_act) > START_MAX) begin
        base_ok = 1'b0; // [R3]
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      CURSOR_EN <= 1'b0;
      INK_EN <= 1'b0;
      BASE_ADDR <= '0;
      BASE_VALID <= 1'b0;
      POS_X <= 11'h000;
      POS_Y <= 11'h000;
      BLUE0 <= 5'h00;
    end else begin
      CURSOR_EN <= (mode_dec == lcic_pkg::LCIC_CURSOR); // [R14]
      INK_EN <= (mode_dec == lcic_pkg::LCIC_INK); // [R14]
      BASE_ADDR <= base_next;
      BASE_VALID <= base_ok;
      // Sign and magnitude; zero outside cursor mode
      if (mode_dec == lcic_pkg::LCIC_CURSOR) begin
        POS_X <= {xhi_act[lcic_pkg::SIGN_BIT], xhi_act[1:0],
          xlo_act}; // [R5] [R7]
        POS_Y <= {yhi_act[lcic_pkg::SIGN_BIT], yhi_act[1:0],
          ylo_act}; // [R6] [R8]
      end else begin
        POS_X <= 11'h000; // [R7]
        POS_Y <= 11'h000; // [R8]
      end
      BLUE0 <= blue_reg; // [R11]
    end
  end

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (rd_go || (AVS_READ && !ack_reg)) begin
      if (idx == lcic_pkg::IDX_MODE) begin
        AVS_READDATA <= {30'h0, mode_reg};
      end else if (idx == lcic_pkg::IDX_START) begin
        AVS_READDATA <= {24'h0, start_reg};
      end else if (idx == lcic_pkg::IDX_XLO) begin
        AVS_READDATA <= {24'h0, xlo_reg};
      end else if (idx == lcic_pkg::IDX_XHI) begin
        AVS_READDATA <= {24'h0, xhi_reg};
      end else if (idx == lcic_pkg::IDX_YLO) begin
        AVS_READDATA <= {24'h0, ylo_reg};
      end else if (idx == lcic_pkg::IDX_YHI) begin
        AVS_READDATA <= {24'h0, yhi_reg};
      end else if (idx == lcic_pkg::IDX_BLUE0) begin
        AVS_READDATA <= {27'h0, blue_reg};
      end else if (idx == lcic_pkg::IDX_STATUS) begin
        AVS_READDATA <= {29'h0, ~base_ok, pos_pend_reg, start_pend_reg};
      end else begin
        AVS_READDATA <= 32'h0000_0000;
      end
    end
  end
endmodule // lcic_regs

// file: verilog/lcic_stage.sv
// Holding register that commits a pending value at an apply strobe.
// Assumes a single clock and synchronous reset.
`timescale 1ns/1ps
module lcic_stage #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pending value and commit strobe
  input wire logic apply,
  input wire logic [W-1:0] d,
  // Committed value
  output logic [W-1:0] q
);
  // Commit on strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (apply) begin
      q <= d;
    end
  end
endmodule // lcic_stage
